// ===== hw/flash_host_seq.sv
// host-side sequencer that erases a block or programs a row of flash
// assumes device registers take one write per dev_req.valid pulse and
// that dev_stall is an asynchronous pin high while the cycle runs
//
// Summary of operation
// RQ1 - one row streamed per program cycle
// RQ2 - erase covers an eight-row block
// RQ3 - erase: opcode 0010, erase set, write enable set
// RQ4 - software loads block address via page pointer
// RQ5 - key 55h then AAh before go
// RQ6 - go bit 15 set after unlock
// RQ7 - device stalls, go clears at end
// RQ8 - program: opcode 0001, erase clear, write enable set
// RQ9 - sixty-four instruction buffer filled before program
// RQ10 - software advances page pointer per row
// RQ11 - software copies eight rows into RAM first
// RQ12 - wait out the programming time
// RQ13 - two idle slots after go
// RQ14 - hold low-priority interrupts over five slots
// RQ15 - wrong key discards the unlock state
// RQ16 - go without write enable is ignored
//
// The Wishbone slave port and the register addresses were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module flash_host_seq (
  // clock and reset
  input  wire logic                     sys_clk,
  input  wire logic                     resetn,
  // classic wishbone slave
  input  wire logic                     wb_cyc_i,
  input  wire logic                     wb_stb_i,
  input  wire logic                     wb_we_i,
  input  wire logic [7:0]               wb_adr_i,
  input  wire logic [3:0]               wb_sel_i,
  input  wire logic [31:0]              wb_dat_i,
  output logic      [31:0]              wb_dat_o,
  output logic                          wb_ack_o,
  // device register port
  output flash_host_pkg::dev_req_t      dev_req,
  input  wire logic                     dev_stall,
  // interrupt hold toward the cpu core
  output logic                          interrupt_hold_instr
);

  // current and next state
  flash_host_pkg::host_state_t s_r;
  flash_host_pkg::host_state_t s_nxt;

  // buffer connections
  logic        buf_we;      // push from the bus
  logic [23:0] buf_rdata;   // registered word
  logic        wb_req;      // new bus cycle

  assign wb_req = wb_cyc_i && wb_stb_i && !s_r.ack;
  assign buf_we = wb_req && wb_we_i && wb_sel_i[0] && !s_r.busy
                  && (wb_adr_i == flash_host_pkg::REG_BUF)
                  && (s_r.fill < 7'(flash_host_pkg::ROW_WORDS));

  // one row of staged instructions, filled by software
  // it holds software's edited copy of the row; see RQ11
  flash_row_buffer u_buf (
    .sys_clk (sys_clk),
    .wr_en   (buf_we),
    .wr_addr (s_r.fill[5:0]),
    .wr_data (wb_dat_i[23:0]),
    .rd_addr (s_r.cnt[5:0]),
    .rd_data (buf_rdata)
  );

  // control word for the selected operation
  function automatic logic [15:0] op_word(input logic erase);
    logic [15:0] w;
    w = 16'h0000;
    w[flash_host_pkg::OPC_WRITE_EN_BIT] = 1'b1;  // see RQ16
    if (erase) begin
      w[3:0] = flash_host_pkg::OPSEL_ERASE;      // see RQ3
      w[flash_host_pkg::OPC_ERASE_BIT] = 1'b1;
    end else begin
      w[3:0] = flash_host_pkg::OPSEL_ROW;        // see RQ8
    end
    return w;
  endfunction

  // next-state logic: bus slave, synchroniser and sequencer
  always_comb begin
    logic start;
    start = 1'b0;
    s_nxt = s_r;
    s_nxt.dev.valid = 1'b0;
    // stall pin passes two flops before use
    s_nxt.stall_m = dev_stall;
    s_nxt.stall_s = s_r.stall_m;
    // ack one cycle after the request, dropped the cycle after
    s_nxt.ack = wb_req;
    if (wb_req) begin
      s_nxt.rdat = 32'h0000_0000;
      unique case (wb_adr_i)
        flash_host_pkg::REG_CTRL: begin
          s_nxt.rdat[flash_host_pkg::CTRL_ERASE_BIT] = s_r.erase;
          if (wb_we_i && wb_sel_i[0]) begin
            if (s_r.busy) begin
              // a second start while running is refused
              s_nxt.refused = s_r.refused
                | wb_dat_i[flash_host_pkg::CTRL_START_BIT];
            end else begin
              s_nxt.erase = wb_dat_i[flash_host_pkg::CTRL_ERASE_BIT];
              start = wb_dat_i[flash_host_pkg::CTRL_START_BIT];
            end
          end
        end
        flash_host_pkg::REG_PAGE: begin
          // software rewrites the page for each row; see RQ10
          s_nxt.rdat[7:0] = s_r.page;
          if (wb_we_i && wb_sel_i[0] && !s_r.busy) begin
            s_nxt.page = wb_dat_i[7:0];
          end
        end
        flash_host_pkg::REG_OFFSET: begin
          s_nxt.rdat[15:0] = s_r.offs;
          if (wb_we_i && !s_r.busy) begin
            if (wb_sel_i[0]) s_nxt.offs[7:0] = wb_dat_i[7:0];
            if (wb_sel_i[1]) s_nxt.offs[15:8] = wb_dat_i[15:8];
          end
        end
        flash_host_pkg::REG_STATUS: begin
          s_nxt.rdat[flash_host_pkg::STAT_BUSY_BIT] = s_r.busy;
          s_nxt.rdat[flash_host_pkg::STAT_DONE_BIT] = s_r.done;
          s_nxt.rdat[flash_host_pkg::STAT_REF_BIT]  = s_r.refused;
          s_nxt.rdat[14:8] = s_r.fill;
          // write one to clear done and refused
          if (wb_we_i && wb_sel_i[0]) begin
            if (wb_dat_i[flash_host_pkg::STAT_DONE_BIT])
              s_nxt.done = 1'b0;
            if (wb_dat_i[flash_host_pkg::STAT_REF_BIT])
              s_nxt.refused = 1'b0;
          end
        end
        flash_host_pkg::REG_BUF: begin
          s_nxt.rdat[6:0] = s_r.fill;
          if (buf_we) s_nxt.fill = s_r.fill + 7'd1;
        end
        default: begin
          // unmapped: acked, reads zero, writes dropped
        end
      endcase
    end

    // sequencer
    unique case (s_r.st)
      flash_host_pkg::ST_IDLE: begin
        if (start) begin
          s_nxt.busy = 1'b1;
          s_nxt.cnt  = '0;
          // erase skips the row stream; a row goes out whole
          if (s_nxt.erase) begin
            s_nxt.st = flash_host_pkg::ST_SETCTL;
          end else begin
            s_nxt.st = flash_host_pkg::ST_LOAD_RD;
          end
        end
      end
      flash_host_pkg::ST_LOAD_RD: begin
        // buffer read address is cnt; data valid next cycle
        s_nxt.st = flash_host_pkg::ST_LOAD_WR;
      end
      flash_host_pkg::ST_LOAD_WR: begin
        s_nxt.dev.valid = 1'b1;                  // see RQ9
        s_nxt.dev.sel   = flash_host_pkg::DSEL_LATCH;
        s_nxt.dev.addr  = s_r.offs + {9'h000, s_r.cnt[5:0], 1'b0};
        s_nxt.dev.data  = buf_rdata;
        s_nxt.cnt = s_r.cnt + 7'h01;
        // exactly one row, never more
        if (s_r.cnt == 7'(flash_host_pkg::ROW_WORDS - 1)) begin
          s_nxt.st = flash_host_pkg::ST_SETCTL;  // see RQ1
        end else begin
          s_nxt.st = flash_host_pkg::ST_LOAD_RD;
        end
      end
      flash_host_pkg::ST_SETCTL: begin
        s_nxt.dev.valid = 1'b1;
        s_nxt.dev.sel   = flash_host_pkg::DSEL_CTRL;
        s_nxt.dev.addr  = 16'h0000;
        s_nxt.dev.data  = {8'h00, op_word(s_r.erase)};
        s_nxt.st = flash_host_pkg::ST_PAGE;
      end
      flash_host_pkg::ST_PAGE: begin
        // block address of the target block
        s_nxt.dev.valid = 1'b1;                  // see RQ4
        s_nxt.dev.sel   = flash_host_pkg::DSEL_PAGE;
        s_nxt.dev.data  = {16'h0000, s_r.page};
        if (s_r.erase) begin
          s_nxt.st = flash_host_pkg::ST_OFFS;
        end else begin
          s_nxt.st = flash_host_pkg::ST_KEY1;
        end
      end
      flash_host_pkg::ST_OFFS: begin
        // a dummy latch write sets the erase base address
        s_nxt.dev.valid = 1'b1;                  // see RQ2
        s_nxt.dev.sel   = flash_host_pkg::DSEL_LATCH;
        s_nxt.dev.addr  = s_r.offs;
        s_nxt.dev.data  = 24'h000000;
        s_nxt.st = flash_host_pkg::ST_KEY1;
      end
      flash_host_pkg::ST_KEY1: begin
        // interrupts held from here through the idle slots
        s_nxt.hold = 1'b1;                       // see RQ14
        s_nxt.dev.valid = 1'b1;                  // see RQ5
        s_nxt.dev.sel   = flash_host_pkg::DSEL_KEY;
        s_nxt.dev.data  = {16'h0000, flash_host_pkg::KEY_FIRST};
        s_nxt.st = flash_host_pkg::ST_KEY2;
      end
      flash_host_pkg::ST_KEY2: begin
        // second key right behind the first, nothing between
        s_nxt.dev.valid = 1'b1;                  // see RQ15
        s_nxt.dev.sel   = flash_host_pkg::DSEL_KEY;
        s_nxt.dev.data  = {16'h0000, flash_host_pkg::KEY_SECOND};
        s_nxt.st = flash_host_pkg::ST_GO;
      end
      flash_host_pkg::ST_GO: begin
        s_nxt.dev.valid = 1'b1;                  // see RQ6
        s_nxt.dev.sel   = flash_host_pkg::DSEL_CTRL;
        s_nxt.dev.data  = {8'h00, op_word(s_r.erase)};
        s_nxt.dev.data[flash_host_pkg::OPC_GO_BIT] = 1'b1;
        s_nxt.nop = '0;
        s_nxt.st = flash_host_pkg::ST_NOP;
      end
      flash_host_pkg::ST_NOP: begin
        // two quiet slots after go
        s_nxt.nop = s_r.nop + 2'h1;              // see RQ13
        if (s_r.nop == 2'(flash_host_pkg::NOP_CYCLES - 1)) begin
          s_nxt.st = flash_host_pkg::ST_WAIT_HI;
        end
      end
      flash_host_pkg::ST_WAIT_HI: begin
        // hold covers two keys, go and both quiet slots, five in all;
        // dropping it a slot early would let an interrupt split them
        s_nxt.hold = 1'b0;                       // see RQ14
        // the stall must be seen before its end counts
        if (s_r.stall_s) begin                   // see RQ12
          s_nxt.st = flash_host_pkg::ST_WAIT_LO;
        end
      end
      flash_host_pkg::ST_WAIT_LO: begin
        if (!s_r.stall_s) begin                  // see RQ7
          s_nxt.busy = 1'b0;
          s_nxt.done = 1'b1;
          if (!s_r.erase) s_nxt.fill = '0;
          s_nxt.st = flash_host_pkg::ST_IDLE;
        end
      end
    endcase
  end

  // state register with synchronous reset
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      s_r <= '{st: flash_host_pkg::ST_IDLE, cnt: '0, fill: '0, nop: '0,
               erase: 1'b0,
               busy: 1'b0, done: 1'b0, refused: 1'b0,
               page: flash_host_pkg::PAGE_RST,
               offs: flash_host_pkg::OFFSET_RST,
               stall_m: 1'b0, stall_s: 1'b0, ack: 1'b0,
               rdat: 32'h0000_0000, hold: 1'b0,
               dev: '{valid: 1'b0, sel: flash_host_pkg::DSEL_CTRL,
                      addr: 16'h0000, data: 24'h000000}};
    end else begin
      s_r <= s_nxt;
    end
  end

  // outputs straight from the state register
  assign wb_ack_o = s_r.ack;
  assign wb_dat_o = s_r.rdat;
  assign dev_req  = s_r.dev;
  assign interrupt_hold_instr = s_r.hold;

  // helper: latch writes since the sequencer left idle, kept for the assertions
  logic [7:0] latch_cnt_r;
  always_ff @(posedge sys_clk) begin
    if (!resetn || (s_r.st == flash_host_pkg::ST_IDLE)) begin
      latch_cnt_r <= 8'h00;
    end else if (dev_req.valid
                 && dev_req.sel == flash_host_pkg::DSEL_LATCH) begin
      latch_cnt_r <= latch_cnt_r + 8'h01;
    end
  end

  // helper decodes of the outgoing write
  logic k1_w, k2_w, go_w;
  assign k1_w = dev_req.valid && dev_req.sel == flash_host_pkg::DSEL_KEY
                && dev_req.data[7:0] == flash_host_pkg::KEY_FIRST;
  assign k2_w = dev_req.valid && dev_req.sel == flash_host_pkg::DSEL_KEY
                && dev_req.data[7:0] == flash_host_pkg::KEY_SECOND;
  assign go_w = dev_req.valid && dev_req.sel == flash_host_pkg::DSEL_CTRL
                && dev_req.data[flash_host_pkg::OPC_GO_BIT];

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!resetn);

  chk_key_pair: assert property ( // see RQ5
    k2_w |-> $past(k1_w)
  ) else $error("second key without first key just before");

  chk_key_lead: assert property ( // see RQ15
    k1_w |=> k2_w ##1 go_w
  ) else $error("unlock sequence broken after first key");

  chk_go_unlock: assert property ( // see RQ6
    go_w |-> $past(k2_w)
  ) else $error("go issued without preceding unlock");

  chk_go_enabled: assert property ( // see RQ16
    go_w |-> dev_req.data[flash_host_pkg::OPC_WRITE_EN_BIT]
  ) else $error("go issued with write enable clear");

  chk_erase_code: assert property ( // see RQ3
    go_w && s_r.erase |-> dev_req.data[3:0] == 4'h2
      && dev_req.data[flash_host_pkg::OPC_ERASE_BIT]
  ) else $error("erase go carries wrong operation code");

  chk_row_code: assert property ( // see RQ8
    go_w && !s_r.erase |-> dev_req.data[3:0] == 4'h1
      && !dev_req.data[flash_host_pkg::OPC_ERASE_BIT]
  ) else $error("program go carries wrong operation code");

  chk_row_words: assert property ( // see RQ1
    go_w && !s_r.erase |-> latch_cnt_r == 8'h40
  ) else $error("row program not preceded by exactly 64 words");

  chk_row_bound: assert property ( // see RQ1
    latch_cnt_r <= 8'h40
  ) else $error("more than one row of latch writes in one cycle");

  chk_erase_base: assert property ( // see RQ2
    go_w && s_r.erase |-> latch_cnt_r == 8'h01
  ) else $error("erase go not preceded by one base address write");

  chk_hold_span: assert property ( // see RQ14
    k1_w |-> interrupt_hold_instr [*5]
  ) else $error("interrupt hold dropped inside unlock window");

  chk_hold_release: assert property ( // see RQ14
    k1_w |=> interrupt_hold_instr [*4] ##1 !interrupt_hold_instr
  ) else $error("interrupt hold not released after five slots");

  chk_quiet_gap: assert property ( // see RQ13
    go_w |=> !dev_req.valid [*2]
  ) else $error("device write within two slots after go");

  chk_end_busy: assert property ( // see RQ7
    s_r.st == flash_host_pkg::ST_WAIT_LO && !s_r.stall_s
      |=> !s_r.busy && s_r.done
  ) else $error("busy not cleared when stall ended");

  chk_busy_idle: assert property ( // see RQ7
    !s_r.busy |-> s_r.st == flash_host_pkg::ST_IDLE
  ) else $error("sequencer running while busy is clear");

endmodule
`default_nettype wire

// ===== hw/flash_host_pkg.sv
// shared constants and types for the flash erase/program host sequencer
// assumes a device-side register port with one write strobe per word
package flash_host_pkg;

  // own wishbone register map (byte offsets)
  localparam logic [7:0] REG_CTRL   = 8'h00; // bit0 start, bit1 erase
  localparam logic [7:0] REG_PAGE   = 8'h04; // table page pointer value
  localparam logic [7:0] REG_OFFSET = 8'h08; // in-page address
  localparam logic [7:0] REG_STATUS = 8'h0C; // busy, done, refused
  localparam logic [7:0] REG_BUF    = 8'h10; // push one 24-bit word

  // own register field positions
  localparam int CTRL_START_BIT = 0;
  localparam int CTRL_ERASE_BIT = 1;
  localparam int STAT_BUSY_BIT  = 0;
  localparam int STAT_DONE_BIT  = 1;
  localparam int STAT_REF_BIT   = 2;

  // device control word fields
  localparam int OPC_GO_BIT    = 15;
  localparam int OPC_WRITE_EN_BIT = 14;
  localparam int OPC_ERASE_BIT = 6;
  localparam logic [3:0] OPSEL_ERASE = 4'h2;
  localparam logic [3:0] OPSEL_ROW   = 4'h1;

  // unlock key values, in the order the device wants them
  localparam logic [7:0] KEY_FIRST  = 8'h55;
  localparam logic [7:0] KEY_SECOND = 8'hAA;

  // sizes and gaps
  localparam int ROW_WORDS  = 64;
  localparam int ROW_AW     = 6;
  localparam int NOP_CYCLES = 2;
  localparam int HOLD_SLOTS = 5;

  // reset values
  localparam logic [7:0]  PAGE_RST   = 8'h00;
  localparam logic [15:0] OFFSET_RST = 16'h0000;

  // which device register a write goes to
  typedef enum logic [2:0] {
    DSEL_CTRL, DSEL_KEY, DSEL_PAGE, DSEL_LATCH
  } dev_sel_t;

  // one write toward the device
  typedef struct packed {
    logic        valid;
    dev_sel_t    sel;
    logic [15:0] addr;
    logic [23:0] data;
  } dev_req_t;

  typedef enum logic [3:0] {
    ST_IDLE, ST_LOAD_RD, ST_LOAD_WR, ST_SETCTL, ST_PAGE, ST_OFFS,
    ST_KEY1, ST_KEY2, ST_GO, ST_NOP, ST_WAIT_HI, ST_WAIT_LO
  } seq_state_t;

  // whole state of the sequencer
  typedef struct packed {
    seq_state_t      st;
    logic [ROW_AW:0] cnt;
    logic [ROW_AW:0] fill;
    logic [1:0]      nop;
    logic            erase;
    logic            busy;
    logic            done;
    logic            refused;
    logic [7:0]      page;
    logic [15:0]     offs;
    logic            stall_m;
    logic            stall_s;
    logic            ack;
    logic [31:0]     rdat;
    logic            hold;
    dev_req_t        dev;
  } host_state_t;

endpackage

// ===== hw/flash_row_buffer.sv
// 64-word staging memory for one row of instructions
// assumes one writer and one reader on the same clock
`timescale 1ns/1ps
`default_nettype none
module flash_row_buffer (
  // clock
  input  wire logic        sys_clk,
  // write side
  input  wire logic        wr_en,
  input  wire logic [5:0]  wr_addr,
  input  wire logic [23:0] wr_data,
  // read side, data one cycle after the address
  input  wire logic [5:0]  rd_addr,
  output var  logic [23:0] rd_data
);

  // storage has no reset: contents are defined by the fill
  logic [23:0] mem [0:flash_host_pkg::ROW_WORDS-1];

  // synchronous write and registered read
  always_ff @(posedge sys_clk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
    rd_data <= mem[rd_addr];
  end

endmodule
`default_nettype wire

// ===== sim/flash_dev_model.sv
// behavioural flash device behind the host sequencer's register port
// assumes one register write per dev_req.valid pulse on sys_clk
`timescale 1ns/1ps
`default_nettype none
module flash_dev_model #(
  parameter int STALL_CYC = 20  // length of one erase or program cycle
) (
  // clock and reset
  input  wire logic                     sys_clk,
  input  wire logic                     resetn,
  // register port from the host
  input  wire flash_host_pkg::dev_req_t dev_req,
  output logic                          dev_stall,
  // observation for the bench
  output logic [15:0]                   ctrl_w,
  output logic [15:0]                   go_w,
  output logic [15:0]                   pg_w,
  output logic [15:0]                   l_addr,
  output logic [23:0]                   l_dat,
  output var int                        n_lat,
  output var int                        n_ops
);
  int         lat_cnt;  // latch writes since the last go
  int         run_cnt;  // cycles left in the running operation
  logic [1:0] unlock;   // 0 locked, 1 first key seen, 2 unlocked

  // stall the host for the whole cycle
  assign dev_stall = (run_cnt != 0);

  // register writes, unlock tracking and the running cycle
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      {ctrl_w, go_w, pg_w, l_addr, l_dat} <= '0;
      {n_lat, n_ops, lat_cnt, run_cnt} <= '0;
      unlock <= 2'h0;
    end else begin
      if (run_cnt == 1) begin
        ctrl_w[15] <= 1'b0; // go clears itself at the end
        n_ops <= n_ops + 1;
      end
      if (run_cnt != 0) run_cnt <= run_cnt - 1;
      if (dev_req.valid) begin
        case (dev_req.sel)
          flash_host_pkg::DSEL_KEY: begin
            // any wrong value other than 55h drops back to locked
            if (dev_req.data[7:0] == flash_host_pkg::KEY_FIRST)
              unlock <= 2'h1;
            else if (unlock == 2'h1 &&
                     dev_req.data[7:0] == flash_host_pkg::KEY_SECOND)
              unlock <= 2'h2;
            else
              unlock <= 2'h0;
          end
          flash_host_pkg::DSEL_PAGE: pg_w <= dev_req.data[15:0];
          flash_host_pkg::DSEL_LATCH: begin
            // keep the last latch address and data, count the write
            l_addr <= dev_req.addr;
            l_dat <= dev_req.data;
            lat_cnt <= lat_cnt + 1;
          end
          default: begin
            ctrl_w <= dev_req.data[15:0];
            // go needs unlock and write enable, else ignored
            if (dev_req.data[15]) begin
              unlock <= 2'h0;
              if (unlock == 2'h2 && dev_req.data[14] && run_cnt == 0) begin
                // erase 0010 hits a block, 0001 one row
                go_w <= dev_req.data[15:0];
                n_lat <= lat_cnt;
                lat_cnt <= 0;
                run_cnt <= STALL_CYC;
              end
            end
          end
        endcase
      end
    end
  end
endmodule
`default_nettype wire

// ===== sim/testbench.sv
// self-checking bench for the flash host sequencer
// assumes the device model answers every accepted go with a stall
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic                     sys_clk;  // 100 MHz
  logic                     resetn;   // active low
  logic                     cyc;
  logic                     stb;
  logic                     we;
  logic [7:0]               adr;
  logic [31:0]              wdat;
  logic [31:0]              dat_o;
  logic [31:0]              rd;       // last read data
  logic                     ack;
  logic                     stall;
  logic                     hold;
  flash_host_pkg::dev_req_t req;
  logic [15:0]              ctrl_w;
  logic [15:0]              go_w;
  logic [15:0]              pg_w;
  logic [15:0]              l_addr;
  logic [23:0]              l_dat;
  int                       n_lat;
  int                       n_ops;
  int                       hold_cyc;
  int                       errors;
  int                       checks_done;

  flash_host_seq DUT (
    .sys_clk(sys_clk), .resetn(resetn), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wdat),
    .wb_dat_o(dat_o), .wb_ack_o(ack), .dev_req(req), .dev_stall(stall),
    .interrupt_hold_instr(hold));

  flash_dev_model dev (
    .sys_clk(sys_clk), .resetn(resetn), .dev_req(req), .dev_stall(stall),
    .ctrl_w(ctrl_w), .go_w(go_w), .pg_w(pg_w), .l_addr(l_addr),
    .l_dat(l_dat), .n_lat(n_lat), .n_ops(n_ops));

  // clock
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  // count cycles of interrupt hold
  always @(posedge sys_clk) if (hold === 1'b1) hold_cyc <= hold_cyc + 1;

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      errors++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic give_verdict;
    $display("checks %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // one classic wishbone cycle, held until ack is sampled
  task automatic bus(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    int k;
    @(posedge sys_clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    for (k = 0; k < 20; k++) begin
      @(posedge sys_clk);
      if (ack === 1'b1) break;
    end
    if (k == 20) begin
      errors++;
      give_verdict();
    end
    rd = dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask

  // poll status until busy falls; the cycle is waited out
  task automatic wait_idle;
    int k;
    for (k = 0; k < 100; k++) begin
      bus(1'b0, flash_host_pkg::REG_STATUS, 32'h0);
      if (rd[0] === 1'b0) break;
    end
    if (k == 100) begin
      errors++;
      give_verdict();
    end
  endtask

  // reset values and an unmapped place
  task automatic run_regs;
    bus(1'b0, flash_host_pkg::REG_STATUS, 32'h0);
    check(rd, 32'h0);
    bus(1'b1, 8'h1C, 32'hFFFF_FFFF);
    bus(1'b0, 8'h1C, 32'h0);
    check(rd, 32'h0);
    check(n_ops, 0);
  endtask

  // block erase with busy seen right after start, before the device stalls
  task automatic run_erase;
    hold_cyc = 0;
    bus(1'b1, flash_host_pkg::REG_PAGE, 32'h12);
    bus(1'b1, flash_host_pkg::REG_OFFSET, 32'h400);
    bus(1'b1, flash_host_pkg::REG_CTRL, 32'h3);
    bus(1'b0, flash_host_pkg::REG_STATUS, 32'h0);
    check(rd[0], 1'b1);
    wait_idle();
    check(rd[2:0], 3'h2);
    check(go_w, 16'hC042);
    check(ctrl_w, 16'h4042);
    check(pg_w, 16'h12);
    check(l_addr, 16'h400);
    check(n_lat, 1);
    check(n_ops, 1);
    check(hold_cyc, 5);
    bus(1'b0, flash_host_pkg::REG_CTRL, 32'h0);
    check(rd, 32'h2);
  endtask

  // fill the row buffer past full, then program one row
  task automatic run_row;
    int i;
    for (i = 0; i < 65; i++)
      bus(1'b1, flash_host_pkg::REG_BUF, 32'hA0_0000 + i);
    bus(1'b0, flash_host_pkg::REG_STATUS, 32'h0);
    check(rd[14:8], 7'd64);
    bus(1'b1, flash_host_pkg::REG_PAGE, 32'h13);
    bus(1'b1, flash_host_pkg::REG_OFFSET, 32'h200);
    bus(1'b1, flash_host_pkg::REG_CTRL, 32'h1);
    wait_idle();
    check(go_w, 16'hC001);
    check(n_lat, 64);
    check(l_addr, 16'h27E);
    check(l_dat, 24'hA0_003F);
    check(n_ops, 2);
    check(pg_w, 16'h13);
    bus(1'b0, flash_host_pkg::REG_BUF, 32'h0);
    check(rd, 32'h0);
  endtask

  // second start and a page write while busy, then clear flags
  task automatic run_refuse;
    bus(1'b1, flash_host_pkg::REG_CTRL, 32'h3);
    bus(1'b1, flash_host_pkg::REG_CTRL, 32'h3);
    bus(1'b1, flash_host_pkg::REG_PAGE, 32'h55);
    wait_idle();
    check(rd[2], 1'b1);
    check(n_ops, 3);
    check(pg_w, 16'h13);
    bus(1'b1, flash_host_pkg::REG_STATUS, 32'h6);
    bus(1'b0, flash_host_pkg::REG_STATUS, 32'h0);
    check(rd[2:0], 3'h0);
  endtask

  // main sequence
  initial begin
    {cyc, stb, we, adr, wdat} = '0;
    {errors, checks_done, hold_cyc} = '0;
    resetn = 1'b0;
    repeat (10) @(posedge sys_clk);
    resetn <= 1'b1;
    run_regs();
    run_erase();
    run_row();
    run_refuse();
    give_verdict();
  end
endmodule
`default_nettype wire
